// [core/scd_decoder.sv]
// SPI target command decoder with 16-bit frames and three 8-bit register banks.
// Assumes sclk, select_line_low_n and si are asynchronous pins and the link
// clock is much slower than clk (about 8 clk periods per sclk period or more).
`timescale 1ns/1ps

// What this block does
// - Frames are exactly sixteen bits long
// - Command nibble on top, address, then data
// - Operational parameters kept in 8-bit registers
// - Write stores frame data to addressed register
// - Read data returns during the next frame
// - Commands accepted anytime in normal state
// - Execute only on select rising edge
// - Command codes zero to seven decoded
// - Fault status register bit layout, reset zero
// - Bit three flags a communication error
// - Configuration, control and status banks kept
// - Bad count or command ignored, error set
// - Check echoes payload with flipped command bits
// - Sample rising, shift falling, MSB first
// - Status writes clear only unless self-test
module scd_decoder
  import scd_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_BITS
) (
  input wire logic clk,                 // 25 MHz system clock
  input wire logic reset,               // Async reset, active high
  input wire logic sclk,                // Serial clock pin
  input wire logic select_line_low_n,   // Select pin, active low
  input wire logic si,                  // Serial data in pin
  input wire logic normal_state,        // Device in normal state
  input wire logic self_test_write_enable, // Status writes unrestricted
  input wire logic [6:0] fault_events,  // Status bits 7..4, 2..0 set events
  output logic so,                      // Serial data out
  output logic so_oe,                   // Drive enable for so
  output logic [REG_W-1:0] fault_status, // Fault status register copy
  output logic cmd_strobe               // One-cycle pulse per executed write
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Idle pin levels: sclk low, select high, si low
  localparam logic [2:0] PINS_IDLE = 3'h2;
  // Pulse count that a valid frame must reach
  localparam logic [CNT_W-1:0] LEN_CNT = CNT_W'(FRAME_LEN);
  logic [2:0] pins_sync;
  scd_sync #(.WIDTH(3), .RESET_VAL(PINS_IDLE)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({sclk, select_line_low_n, si}),
    .sync_out(pins_sync)
  );
  wire logic sclk_s = pins_sync[2];
  wire logic sel_n_s = pins_sync[1];
  wire logic si_s = pins_sync[0];

  // ************************************************************
  // Link state
  // ************************************************************
  typedef enum logic [1:0] {
    SCD_IDLE  = 2'b00,
    SCD_FRAME = 2'b01,
    SCD_DONE  = 2'b11
  } scd_state_t;

  scd_state_t state_reg, state_next;
  logic sclk_d_reg, sclk_d_next;
  logic sel_d_reg, sel_d_next;
  logic [FRAME_BITS-1:0] shin_reg, shin_next;
  logic [FRAME_BITS-1:0] shout_reg, shout_next;
  logic [FRAME_BITS-1:0] resp_reg, resp_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic so_next, so_oe_next, strobe_next;

  logic [REG_W-1:0] cfg_mem [BANK_DEPTH];
  logic [REG_W-1:0] ctrl_mem [BANK_DEPTH];
  logic [REG_W-1:0] stat_mem [BANK_DEPTH];
  logic [REG_W-1:0] fault_next;
  logic wr_cfg, wr_ctrl, wr_stat;
  logic [3:0] wr_addr;
  logic [REG_W-1:0] wr_data;

  wire logic sclk_rise = sclk_s & ~sclk_d_reg;
  wire logic sclk_fall = ~sclk_s & sclk_d_reg;
  wire logic sel_fall = ~sel_n_s & sel_d_reg;
  wire logic sel_rise = sel_n_s & ~sel_d_reg;

  // Combines status write policy with the stored value
  function automatic logic [REG_W-1:0] stat_write(input logic [REG_W-1:0] cur,
                                                  input logic [REG_W-1:0] dat,
                                                  input logic free);
    stat_write = free ? dat : (cur & dat);
  endfunction

  // Frame decode, response build and register write request
  always_comb begin
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [REG_W-1:0] data;
    logic bad;
    cmd = shin_reg[CMD_MSB:CMD_LSB];
    addr = shin_reg[ADDR_MSB:ADDR_LSB];
    data = shin_reg[DATA_MSB:0];
    bad = 1'b0;
    state_next = state_reg;
    sclk_d_next = sclk_s;
    sel_d_next = sel_n_s;
    shin_next = shin_reg;
    shout_next = shout_reg;
    resp_next = resp_reg;
    cnt_next = cnt_reg;
    so_next = so;
    so_oe_next = so_oe;
    strobe_next = 1'b0;
    wr_cfg = 1'b0;
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_addr = addr;
    wr_data = data;
    unique case (state_reg)
      SCD_IDLE: begin
        so_oe_next = 1'b0;
        if (sel_fall) begin
          state_next = SCD_FRAME;
          cnt_next = '0;
          so_oe_next = 1'b1;
          shout_next = resp_reg;
          so_next = resp_reg[FRAME_BITS-1];
        end
      end
      SCD_FRAME: begin
        if (sclk_rise) begin
          shin_next = {shin_reg[FRAME_BITS-2:0], si_s};
          if (cnt_reg != '1)
            cnt_next = cnt_reg + 1'b1;
        end
        if (sclk_fall) begin
          shout_next = {shout_reg[FRAME_BITS-2:0], 1'b0};
          so_next = shout_reg[FRAME_BITS-2];
        end
        if (sel_rise) begin
          state_next = SCD_DONE;
          so_oe_next = 1'b0;
        end
      end
      SCD_DONE: begin
        // Execute only after select returns high
        state_next = SCD_IDLE;
        resp_next = shin_reg;
        if (cnt_reg != LEN_CNT) begin
          bad = 1'b1;
        end else if (normal_state) begin
          unique case (cmd)
            SCD_CHECK: resp_next = {cmd ^ CHECK_FLIP, shin_reg[ADDR_MSB:0]};
            SCD_RD_CFG: resp_next = {cmd, addr, cfg_mem[addr]};
            SCD_RD_STAT: resp_next = {cmd, addr, stat_mem[addr]};
            SCD_RD_CTRL: resp_next = {cmd, addr, ctrl_mem[addr]};
            SCD_WR_CFG: wr_cfg = 1'b1;
            SCD_WR_STAT: wr_stat = 1'b1;
            SCD_WR_CTRL: wr_ctrl = 1'b1;
            SCD_CHECK_RESP: resp_next = shin_reg;
            default: bad = 1'b1;
          endcase
          strobe_next = wr_cfg | wr_ctrl | wr_stat;
        end
      end
      default: state_next = SCD_IDLE;
    endcase
    if (!normal_state) begin
      wr_cfg = 1'b0;
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      strobe_next = 1'b0;
    end
    // Fault status: events set, writes per policy, error sticky
    fault_next = fault_status;
    if (wr_stat && addr == FAULT_STAT_ADDR)
      fault_next = stat_write(fault_status, data, self_test_write_enable);
    // Hardware events set bits only while self-test writes are off, set wins
    if (!self_test_write_enable) begin
      fault_next[ANY_FAULT_BIT] = fault_next[ANY_FAULT_BIT] | fault_events[6];
      fault_next[KEYSW_BIT] = fault_next[KEYSW_BIT] | fault_events[5];
      fault_next[PWREN_BIT] = fault_next[PWREN_BIT] | fault_events[4];
      fault_next[BATSW_BIT] = fault_next[BATSW_BIT] | fault_events[3];
      fault_next[PROT_STB_BIT] = fault_next[PROT_STB_BIT] | fault_events[2];
      fault_next[PROT_OT_BIT] = fault_next[PROT_OT_BIT] | fault_events[1];
      fault_next[PROT_STG_BIT] = fault_next[PROT_STG_BIT] | fault_events[0];
    end
    if (bad)
      fault_next[SPI_ERR_BIT] = 1'b1;
  end

  // Link state registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= SCD_IDLE;
      sclk_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      shin_reg <= '0;
      shout_reg <= '0;
      resp_reg <= '0;
      cnt_reg <= '0;
      so <= 1'b0;
      so_oe <= 1'b0;
      cmd_strobe <= 1'b0;
      fault_status <= FAULT_STAT_RESET;
    end else begin
      state_reg <= state_next;
      sclk_d_reg <= sclk_d_next;
      sel_d_reg <= sel_d_next;
      shin_reg <= shin_next;
      shout_reg <= shout_next;
      resp_reg <= resp_next;
      cnt_reg <= cnt_next;
      so <= so_next;
      so_oe <= so_oe_next;
      cmd_strobe <= strobe_next;
      fault_status <= fault_next;
    end
  end

  // ************************************************************
  // Register banks
  // ************************************************************
  // Three banks of 8-bit registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < BANK_DEPTH; i++) begin
        cfg_mem[i] <= REG_RESET;
        ctrl_mem[i] <= REG_RESET;
        stat_mem[i] <= REG_RESET;
      end
    end else begin
      if (wr_cfg)
        cfg_mem[wr_addr] <= wr_data;
      if (wr_ctrl)
        ctrl_mem[wr_addr] <= wr_data;
      if (wr_stat)
        stat_mem[wr_addr] <= stat_write(stat_mem[wr_addr], wr_data, self_test_write_enable);
      stat_mem[FAULT_STAT_ADDR] <= fault_next;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_err_on_count: assert property (@(posedge clk) disable iff (reset)
    (state_reg == SCD_DONE && cnt_reg != FRAME_CNT) |=> fault_status[SPI_ERR_BIT])
    else $error("short or long frame did not flag error");
  a_no_wr_bad_cnt: assert property (@(posedge clk) disable iff (reset)
    (state_reg == SCD_DONE && cnt_reg != FRAME_CNT) |=> !cmd_strobe)
    else $error("bad frame executed");
  a_exec_after_sel: assert property (@(posedge clk) disable iff (reset)
    cmd_strobe |-> $past(state_reg) == SCD_DONE)
    else $error("write executed outside frame end");
  a_so_off_idle: assert property (@(posedge clk) disable iff (reset)
    (state_reg == SCD_IDLE && !sel_fall) |=> !so_oe)
    else $error("so driven while deselected");
  a_err_sticky: assert property (@(posedge clk) disable iff (reset)
    (fault_status[SPI_ERR_BIT] && !wr_stat) |=> fault_status[SPI_ERR_BIT])
    else $error("error flag lost");
  a_clear_only: assert property (@(posedge clk) disable iff (reset)
    (wr_stat && wr_addr == FAULT_STAT_ADDR && !self_test_write_enable && !fault_status[PROT_STG_BIT]
     && !fault_events[0]) |=> !fault_status[PROT_STG_BIT])
    else $error("status bit set by write without self-test");
  a_ignore_abnormal: assert property (@(posedge clk) disable iff (reset)
    !$past(normal_state) |-> !cmd_strobe)
    else $error("command executed outside normal state");
  a_check_resp: assert property (@(posedge clk) disable iff (reset)
    (state_reg == SCD_DONE && cnt_reg == FRAME_CNT && normal_state && shin_reg[CMD_MSB:CMD_LSB] == SCD_CHECK)
    |=> resp_reg == {CHECK_FLIP, $past(shin_reg[ADDR_MSB:0])})
    else $error("check response wrong");

endmodule

// [core/scd_sync.sv]
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes inputs come from outside the clk domain.
`timescale 1ns/1ps
module scd_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0 // Idle levels of the pins
) (
  input wire logic clk,                 // System clock
  input wire logic reset,               // Async reset, active high
  input wire logic [WIDTH-1:0] async_in, // Pin levels
  output logic [WIDTH-1:0] sync_out     // Synchronised levels
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  // Next values of both stages
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Stage registers; reset to idle levels so no false edge follows reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_out <= sync_next;
    end
  end

endmodule

// [inc/scd_pkg.sv]
// Constants for the SPI command decoder: frame layout, commands, register
// map and reset values. Assumes nothing beyond a SystemVerilog compiler.
package scd_pkg;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int FRAME_BITS = 16;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int ADDR_MSB = 11;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_CNT = 5'h10;

  // ************************************************************
  // Command codes
  // ************************************************************
  typedef enum logic [3:0] {
    SCD_CHECK      = 4'h0,
    SCD_RD_CFG     = 4'h1,
    SCD_WR_CFG     = 4'h2,
    SCD_RD_STAT    = 4'h3,
    SCD_WR_STAT    = 4'h4,
    SCD_RD_CTRL    = 4'h5,
    SCD_WR_CTRL    = 4'h6,
    SCD_CHECK_RESP = 4'h7
  } scd_cmd_t;

  // Check response: flip mask on the command nibble
  localparam logic [3:0] CHECK_FLIP = 4'h7;

  // ************************************************************
  // Register banks
  // ************************************************************
  localparam int REG_W = 8;
  localparam int BANK_DEPTH = 16;
  localparam logic [3:0] FAULT_STAT_ADDR = 4'hd;
  localparam logic [7:0] FAULT_STAT_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int SPI_ERR_BIT = 3;
  localparam int ANY_FAULT_BIT = 7;
  localparam int KEYSW_BIT = 6;
  localparam int PWREN_BIT = 5;
  localparam int BATSW_BIT = 4;
  localparam int PROT_STB_BIT = 2;
  localparam int PROT_OT_BIT = 1;
  localparam int PROT_STG_BIT = 0;

endpackage

// [sim/scd_host_model.sv]
// Host controller model driving the serial link of the command decoder.
// Assumes a free-running clk that only paces the serial clock.
`timescale 1ns/1ps
module scd_host_model (
  input wire logic clk, // Pacing clock
  input wire logic so, // Device serial out
  input wire logic so_oe, // Device drive enable
  output logic sclk, // Serial clock, idle low
  output logic select_line_low_n, // Select, active low
  output logic si // Serial data to device
);
  // ************************************************************
  // Frame engine
  // ************************************************************
  int half = 4; // Clk cycles per half serial period
  // Idle levels
  initial begin
    sclk = 1'b0;
    select_line_low_n = 1'b1;
    si = 1'b0;
  end
  // One frame of nbits pulses, reply shifted in
  task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk);
    select_line_low_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      si = tx[15-i];
      repeat (half) @(negedge clk);
      rx = {rx[14:0], (so_oe === 1'b1) ? so : 1'bx};
      sclk = 1'b1;
      repeat (half) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (half) @(negedge clk);
    select_line_low_n = 1'b1;
    // Released data line flips, never holds
    si = ~si;
    repeat (16) @(negedge clk);
  endtask
endmodule

// [sim/spi_command_decoder_tb.sv]
// Self-checking bench for the SPI command decoder.
// Assumes the host model paces frames; bench drives levels at clk fall.
`timescale 1ns/1ps
`define SCD_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module spi_command_decoder_tb;
  import scd_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clk, reset, sclk, select_line_low_n, si, normal_state;
  logic self_test_write_enable, so, so_oe, cmd_strobe;
  logic [6:0] fault_events;
  logic [7:0] fault_status;
  logic [15:0] rx;
  int bad_count = 0;
  int cmp_count = 0;
  int strobes = 0;
  scd_decoder #(.FRAME_LEN(16)) dut (.clk(clk), .reset(reset), .sclk(sclk),
    .select_line_low_n(select_line_low_n), .si(si), .normal_state(normal_state),
    .self_test_write_enable(self_test_write_enable), .fault_events(fault_events),
    .so(so), .so_oe(so_oe), .fault_status(fault_status), .cmd_strobe(cmd_strobe));
  scd_host_model host (.clk(clk), .so(so), .so_oe(so_oe), .sclk(sclk),
    .select_line_low_n(select_line_low_n), .si(si));
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Count write strobes
  always @(posedge clk) begin
    if (cmd_strobe === 1'b1) strobes++;
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  // Full frame
  task automatic xfer(input logic [15:0] tx);
    host.frame(tx, 16, rx);
  endtask
  // Read request, then a check frame collects the reply
  task automatic rd(input logic [3:0] cmd, input logic [3:0] a, input logic [7:0] e);
    xfer({cmd, a, 8'h00});
    xfer(16'h0000);
    `SCD_CHK(rx, {cmd, a, e})
  endtask
  // Verdict and end of run
  task automatic final_report();
    $display("counts: compared %0d, mismatched %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset state
  task automatic t_reset();
    `SCD_CHK(fault_status, 8'h00)
    `SCD_CHK(so_oe, 1'b0)
  endtask
  // Separate config and control banks, addresses 3 and f
  task automatic t_banks();
    logic [3:0] w[2] = '{SCD_WR_CFG, SCD_WR_CTRL};
    logic [3:0] r[2] = '{SCD_RD_CFG, SCD_RD_CTRL};
    logic [3:0] a[2] = '{4'h3, 4'hf};
    int s0;
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 2; j++) begin
        s0 = strobes;
        xfer({w[k], a[j], 4'(k + 5), a[j]});
        `SCD_CHK(strobes, s0 + 1)
      end
    end
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 2; j++) begin
        rd(r[k], a[j], {4'(k + 5), a[j]});
      end
    end
  endtask
  // Check echo and check-response code
  task automatic t_check();
    xfer(16'h0abc);
    xfer(16'h7123);
    `SCD_CHK(rx, 16'h7abc)
    xfer(16'h0000);
    `SCD_CHK(rx, 16'h7123)
    `SCD_CHK(fault_status[SPI_ERR_BIT], 1'b0)
  endtask
  // Short frame and bad code are ignored and flagged
  task automatic t_errors();
    host.frame({3'b010, 4'h3, 8'h3e, 1'b0}, 15, rx);
    `SCD_CHK(fault_status, 8'h08)
    rd(SCD_RD_CFG, 4'h3, 8'h53);
    xfer({SCD_WR_STAT, 4'hd, 8'h00});
    `SCD_CHK(fault_status, 8'h00)
    xfer(16'h8d00);
    `SCD_CHK(fault_status[SPI_ERR_BIT], 1'b1)
    xfer({SCD_WR_STAT, 4'hd, 8'h00});
  endtask
  // Self-test writes, clear-only writes, hardware events
  task automatic t_status();
    @(negedge clk) self_test_write_enable = 1'b1;
    xfer({SCD_WR_STAT, 4'hd, 8'h5a});
    `SCD_CHK(fault_status, 8'h5a)
    @(negedge clk) fault_events = 7'h01;
    repeat (4) @(negedge clk) fault_events = 7'h00;
    rd(SCD_RD_STAT, 4'hd, 8'h5a);
    @(negedge clk) self_test_write_enable = 1'b0;
    xfer({SCD_WR_STAT, 4'hd, 8'hff});
    `SCD_CHK(fault_status, 8'h5a)
    xfer({SCD_WR_STAT, 4'hd, 8'h0f});
    `SCD_CHK(fault_status, 8'h0a)
    xfer({SCD_WR_STAT, 4'hd, 8'h00});
    @(negedge clk) fault_events = 7'h40;
    repeat (4) @(negedge clk) fault_events = 7'h00;
    repeat (4) @(negedge clk);
    `SCD_CHK(fault_status, 8'h80)
    xfer({SCD_WR_STAT, 4'hd, 8'h00});
  endtask
  // Out of Normal state nothing changes; slow host
  task automatic t_normal();
    int s0;
    host.half = 8;
    s0 = strobes;
    @(negedge clk) normal_state = 1'b0;
    xfer({SCD_WR_CFG, 4'h3, 8'h77});
    `SCD_CHK(strobes, s0)
    @(negedge clk) normal_state = 1'b1;
    rd(SCD_RD_CFG, 4'h3, 8'h53);
    host.half = 4;
  endtask
  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  // Reset, then all scenarios
  initial begin
    reset = 1'b1;
    normal_state = 1'b1;
    self_test_write_enable = 1'b0;
    fault_events = 7'h00;
    repeat (6) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_banks();
    t_check();
    t_errors();
    t_status();
    t_normal();
    final_report();
  end
  // Cut a hang short
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule
